// ===== core/pli_init_ctl.sv
// Device end of the parallel link interface: power-status handling,
// initialization, control-pair ownership and request stream capture.
// Assumes pins are resolved outside from the low-active enables.
//
// Notes on behaviour
// RULE1: Link reasserts power status after restore interval.
// RULE2: Interface clock restarts after power-status reassertion.
// RULE3: Init interface clock is 50 percent square.
// RULE4: First seven clock cycles drive everything low.
// RULE5: Link drives low once, else floats.
// RULE6: Link holds request line low during init.
// RULE7: Eighth cycle: receive code, data all ones.
// RULE8: Then idle code; requests accepted afterwards.
// RULE9: Link returns clock; link transfers use it. Only the request deframer uses it here; bus_in is sampled on clk.
// RULE10: Outputs change on interface clock rising edge.
// RULE11: All eight data lines used per transfer.
// RULE12: Link sends requests serially on request line.
// RULE13: Power-status line resets or stops interface.
// RULE14: Wake line flags inactive power or link-off.
// RULE15: Status information shifted out serially.
// RULE16: Device owns buses until it grants them.
// RULE17: Status transfers autonomous or read answers.
// RULE18: Every arriving packet starts a receive.
// RULE19: Arbitration won leads to grant code.
// RULE20: Device codes: idle, status, receive, grant.
// RULE21: Link codes: idle, transmit, hold; 10 reserved.
// RULE22: One request bit per clock sample.
// RULE23: Restore interval is at least 15 us.
// RULE24: Reset at 2.60 us, disable at 26.03 us.
// RULE25: Start bit one, stop bit zero, idle low.
// RULE26: Request activity before init is discarded.
`timescale 1ns/100ps
module pli_init_ctl
  import pli_pkg::*;
#(
  parameter int ACT_LP_CYCLES = ACT_LP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_return_clock,
  input wire logic link_power_status,
  input wire logic low_power_state,
  input wire logic link_active_bit,
  output logic iface_clk_out,
  output pli_pins_t bus_out,
  output logic bus_oe_n,
  input wire pli_pins_t bus_in,
  input wire logic link_request_line,
  output logic link_wake_line,
  output logic phy_serial_status_line,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic st_valid,
  input wire logic [7:0] st_data,
  output logic st_ready,
  input wire logic grant_req,
  output logic grant_ack,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic irq_valid,
  input wire logic [7:0] irq_data,
  output logic irq_ready,
  output logic req_valid,
  output pli_req_t req,
  output logic init_done
);

  ////////////////////////////////////////////////////////////////////
  // Core domain state
  pli_state_t st_ff, nxt_st;
  logic lps_s1_ff, lps_s2_ff;
  pli_pins_t bin_s1_ff, bin_s2_ff;
  logic [9:0] lo_ff, nxt_lo;
  logic [16:0] wait_ff, nxt_wait;
  logic [3:0] div_ff, nxt_div;
  logic pclk_ff, nxt_pclk;
  logic [2:0] icnt_ff, nxt_icnt;
  pli_pins_t bus_ff, nxt_bus;
  logic oe_n_ff, nxt_oe_n;
  logic seen_ff, nxt_seen;
  logic txv_ff, nxt_txv;
  logic [7:0] txd_ff, nxt_txd;
  logic [8:0] ish_ff, nxt_ish;
  logic [3:0] ibit_ff, nxt_ibit;
  logic wake_ff, nxt_wake;
  logic t1_ff, t2_ff, t3_ff;
  logic rqv_ff, nxt_rqv;
  pli_req_t rq_ff, nxt_rq;
  logic run, rise, norm;
  // Link domain state
  logic ld_s1_ff, ld_s2_ff;
  logic lr_s1_ff, lr_s2_ff;
  logic [REQ_MAX-1:0] lsh_ff, nxt_lsh;
  logic [4:0] lcnt_ff, nxt_lcnt;
  logic [4:0] llen_ff, nxt_llen;
  logic lbusy_ff, nxt_lbusy;
  pli_req_t lword_ff, nxt_lword;
  logic ltog_ff, nxt_ltog;

  function automatic logic [4:0] pli_len(input logic [3:0] rtype);
    logic [4:0] len;
    len = LEN_SHORT;
    if (rtype >= RT_BUS_FIRST && rtype <= RT_BUS_LAST) begin
      len = LEN_BUS;
    end else if (rtype == RT_READ) begin
      len = LEN_READ;
    end else if (rtype == RT_WRITE) begin
      len = LEN_WRITE;
    end
    return len;
  endfunction : pli_len

  ////////////////////////////////////////////////////////////////////
  // Clock runs in every state but disabled and waking
  assign run = !(st_ff inside {ST_DIS, ST_WAKE}); // [RULE2]
  assign rise = run && !pclk_ff && (div_ff == 4'(PCLK_HALF - 1)); // [RULE10]
  assign norm = (st_ff == ST_NORM);
  assign init_done = norm || (st_ff == ST_LINK); // [RULE8]
  assign rx_ready = rise && norm && rx_valid; // [RULE18]
  assign st_ready = rise && norm && !rx_valid && st_valid; // [RULE17]
  assign grant_ack = rise && norm && !rx_valid && !st_valid && grant_req;
  assign irq_ready = rise && (ibit_ff == 4'h0) && irq_valid;
  assign iface_clk_out = pclk_ff;
  assign bus_out = bus_ff;
  assign bus_oe_n = oe_n_ff;
  assign tx_valid = txv_ff;
  assign tx_data = txd_ff;
  assign phy_serial_status_line = ish_ff[8];
  assign link_wake_line = wake_ff;
  assign req_valid = rqv_ff;
  assign req = rq_ff;

  always_comb begin
    nxt_st = st_ff;
    nxt_wait = wait_ff;
    nxt_icnt = icnt_ff;
    nxt_bus = bus_ff;
    nxt_oe_n = oe_n_ff;
    nxt_seen = seen_ff;
    nxt_txv = 1'b0;
    nxt_txd = txd_ff;
    nxt_lo = lo_ff;
    if (lps_s2_ff) begin
      nxt_lo = '0;
    end else if (lo_ff < 10'(DISABLE_CYC)) begin
      nxt_lo = lo_ff + 10'h001;
    end
    nxt_div = '0;
    nxt_pclk = 1'b0;
    if (run) begin
      // Equal halves keep the duty at fifty percent
      nxt_div = (div_ff == 4'(PCLK_HALF - 1)) ? 4'h0 : div_ff + 4'h1; // [RULE3]
      nxt_pclk = (div_ff == 4'(PCLK_HALF - 1)) ? !pclk_ff : pclk_ff;
    end
    unique case (st_ff)
      ST_DIS: begin
        if (lps_s2_ff) begin
          // Waking from low power is slow by design
          nxt_wait = low_power_state ? 17'(ACT_LP_CYCLES) : 17'(ACT_NORM_CYC); // [RULE2]
          nxt_st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!lps_s2_ff) begin
          nxt_st = ST_DIS;
        end else if (wait_ff <= 17'h00001) begin
          nxt_st = ST_INIT;
          nxt_icnt = '0;
        end else begin
          nxt_wait = wait_ff - 17'h00001;
        end
      end
      ST_RST: begin
        if (lps_s2_ff) begin
          nxt_st = ST_INIT;
          nxt_icnt = '0;
        end
      end
      ST_INIT: begin
        nxt_bus = '{ctl: CTL_IDLE, data: DATA_ZERO}; // [RULE4]
        nxt_oe_n = 1'b0;
        if (rise) begin
          if (icnt_ff == 3'(INIT_LOW_CYC)) begin
            nxt_bus = '{ctl: CTL_RECEIVE, data: DATA_ON}; // [RULE7]
            nxt_st = ST_RXI;
          end else begin
            nxt_icnt = icnt_ff + 3'h1;
          end
        end
      end
      ST_RXI: begin
        if (rise) begin
          nxt_bus = '{ctl: CTL_IDLE, data: DATA_ZERO}; // [RULE8]
          nxt_st = ST_NORM;
        end
      end
      ST_NORM: begin
        if (rise) begin
          nxt_bus = '{ctl: CTL_IDLE, data: DATA_ZERO}; // [RULE20]
          if (rx_valid) begin
            nxt_bus = '{ctl: CTL_RECEIVE, data: rx_data}; // [RULE11]
          end else if (st_valid) begin
            nxt_bus = '{ctl: CTL_STATUS, data: st_data}; // [RULE17]
          end else if (grant_req) begin
            nxt_bus = '{ctl: CTL_GRANT, data: DATA_ZERO}; // [RULE19]
            nxt_seen = 1'b0;
            nxt_st = ST_LINK;
          end
        end
      end
      ST_LINK: begin
        if (rise) begin
          nxt_oe_n = 1'b1; // [RULE16]
          if (bin_s2_ff.ctl != LCTL_IDLE) begin
            nxt_seen = 1'b1;
          end
          // Reserved link code is neither transmit nor release
          if (bin_s2_ff.ctl == LCTL_TRANSMIT) begin
            nxt_txv = 1'b1; // [RULE21]
            nxt_txd = bin_s2_ff.data;
          end
          if (seen_ff && bin_s2_ff.ctl == LCTL_IDLE) begin
            nxt_oe_n = 1'b0; // [RULE16]
            nxt_bus = '{ctl: CTL_IDLE, data: DATA_ZERO};
            nxt_st = ST_NORM;
          end
        end
      end
    endcase
    // Deasserted power status: reset first, then stop the clock
    if (lo_ff == 10'(RESET_CYC - 1) && !(st_ff inside {ST_DIS, ST_RST})) begin
      nxt_st = ST_RST; // [RULE24] [RULE13]
      nxt_bus = '{ctl: CTL_IDLE, data: DATA_ZERO};
      nxt_oe_n = 1'b0;
    end
    if (lo_ff == 10'(DISABLE_CYC - 1)) begin
      nxt_st = ST_DIS; // [RULE24]
      nxt_bus = '{ctl: CTL_IDLE, data: DATA_ZERO};
      nxt_oe_n = 1'b0;
    end
  end

  // Serial status shifter and wake flag
  always_comb begin
    nxt_ish = ish_ff;
    nxt_ibit = ibit_ff;
    if (!run) begin
      nxt_ish = '0;
      nxt_ibit = '0;
    end else if (rise) begin
      if (ibit_ff == 4'h0) begin
        if (irq_valid) begin
          nxt_ish = {1'b1, irq_data}; // [RULE15]
          nxt_ibit = 4'h9;
        end
      end else begin
        nxt_ish = {ish_ff[7:0], 1'b0};
        nxt_ibit = ibit_ff - 4'h1;
      end
    end
    nxt_wake = !lps_s2_ff || !link_active_bit; // [RULE14]
  end

  // Request words cross by toggle; word is stable long before it
  always_comb begin
    nxt_rqv = 1'b0;
    nxt_rq = rq_ff;
    if ((t2_ff != t3_ff) && init_done) begin
      nxt_rqv = 1'b1; // [RULE8] [RULE26]
      nxt_rq = lword_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_DIS;
      lps_s1_ff <= 1'b0;
      lps_s2_ff <= 1'b0;
      bin_s1_ff <= '0;
      bin_s2_ff <= '0;
      lo_ff <= '0;
      wait_ff <= '0;
      div_ff <= '0;
      pclk_ff <= 1'b0;
      icnt_ff <= '0;
      bus_ff <= '0;
      oe_n_ff <= 1'b0;
      seen_ff <= 1'b0;
      txv_ff <= 1'b0;
      txd_ff <= '0;
      ish_ff <= '0;
      ibit_ff <= '0;
      wake_ff <= 1'b1;
      t1_ff <= 1'b0;
      t2_ff <= 1'b0;
      t3_ff <= 1'b0;
      rqv_ff <= 1'b0;
      rq_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      lps_s1_ff <= link_power_status;
      lps_s2_ff <= lps_s1_ff;
      bin_s1_ff <= bus_in;
      bin_s2_ff <= bin_s1_ff;
      lo_ff <= nxt_lo;
      wait_ff <= nxt_wait;
      div_ff <= nxt_div;
      pclk_ff <= nxt_pclk;
      icnt_ff <= nxt_icnt;
      bus_ff <= nxt_bus;
      oe_n_ff <= nxt_oe_n;
      seen_ff <= nxt_seen;
      txv_ff <= nxt_txv;
      txd_ff <= nxt_txd;
      ish_ff <= nxt_ish;
      ibit_ff <= nxt_ibit;
      wake_ff <= nxt_wake;
      t1_ff <= ltog_ff;
      t2_ff <= t1_ff;
      t3_ff <= t2_ff;
      rqv_ff <= nxt_rqv;
      rq_ff <= nxt_rq;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link domain: request stream deframer on the returned clock
  always_comb begin
    nxt_lsh = lsh_ff;
    nxt_lcnt = lcnt_ff;
    nxt_llen = llen_ff;
    nxt_lbusy = lbusy_ff;
    nxt_lword = lword_ff;
    nxt_ltog = ltog_ff;
    if (!ld_s2_ff) begin
      nxt_lbusy = 1'b0; // [RULE26] [RULE6]
      nxt_lcnt = '0;
    end else if (!lbusy_ff) begin
      if (lr_s2_ff) begin
        nxt_lbusy = 1'b1; // [RULE25]
        nxt_lsh = {{(REQ_MAX-1){1'b0}}, 1'b1};
        nxt_lcnt = 5'h01;
        nxt_llen = LEN_WRITE;
      end
    end else begin
      nxt_lsh = {lsh_ff[REQ_MAX-2:0], lr_s2_ff}; // [RULE22] [RULE12]
      nxt_lcnt = lcnt_ff + 5'h01;
      if (lcnt_ff == 5'(TYPE_LAST_BIT)) begin
        nxt_llen = pli_len({lsh_ff[2:0], lr_s2_ff});
      end else if (lcnt_ff == llen_ff - 5'h01) begin
        nxt_lbusy = 1'b0;
        // Bad stop bit drops this word only
        if (!lr_s2_ff) begin
          nxt_lword = '{len: llen_ff, bits: nxt_lsh}; // [RULE25]
          nxt_ltog = !ltog_ff;
        end
      end
    end
  end

  always_ff @(posedge link_return_clock or posedge rst) begin // [RULE9]
    if (rst) begin
      ld_s1_ff <= 1'b0;
      ld_s2_ff <= 1'b0;
      lr_s1_ff <= 1'b0;
      lr_s2_ff <= 1'b0;
      lsh_ff <= '0;
      lcnt_ff <= '0;
      llen_ff <= '0;
      lbusy_ff <= 1'b0;
      lword_ff <= '0;
      ltog_ff <= 1'b0;
    end else begin
      ld_s1_ff <= init_done;
      ld_s2_ff <= ld_s1_ff;
      lr_s1_ff <= link_request_line;
      lr_s2_ff <= lr_s1_ff;
      lsh_ff <= nxt_lsh;
      lcnt_ff <= nxt_lcnt;
      llen_ff <= nxt_llen;
      lbusy_ff <= nxt_lbusy;
      lword_ff <= nxt_lword;
      ltog_ff <= nxt_ltog;
    end
  end

endmodule : pli_init_ctl

// ===== core/pli_pkg.sv
// Shared constants and carriers for the link-side parallel interface.
// Assumes a 20 MHz core clock; times are converted to cycles here.
package pli_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int INIT_CLK_HZ = 49_152_000;
  localparam int IFACE_CLK_HZ = 98_304_000;
  localparam int IFACE_CLK_PPM = 100;
  // Divider half period; the core clock is far below either rate
  localparam int PCLK_HALF_RAW = CLK_HZ / (2 * INIT_CLK_HZ);
  localparam int PCLK_HALF = (PCLK_HALF_RAW < 1) ? 1 : PCLK_HALF_RAW;
  localparam int T_RESET_MIN_NS = 2600;
  localparam int T_DISABLE_MIN_NS = 26030;
  localparam int T_ACT_NORM_MAX_NS = 60;
  localparam int T_ACT_LP_MIN_US = 5300;
  localparam int RESET_CYC = (T_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISABLE_CYC = (T_DISABLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACT_NORM_RAW = T_ACT_NORM_MAX_NS / CLK_PERIOD_NS;
  localparam int ACT_NORM_CYC = (ACT_NORM_RAW < 1) ? 1 : ACT_NORM_RAW;
  localparam int ACT_LP_CYC = (T_ACT_LP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_LOW_CYC = 7;
  localparam int REQ_MAX = 18;
  localparam int TYPE_LAST_BIT = 4;
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;
  localparam logic [1:0] LCTL_IDLE = 2'h0;
  localparam logic [1:0] LCTL_TRANSMIT = 2'h1;
  localparam logic [7:0] DATA_ON = 8'hff;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [3:0] RT_BUS_FIRST = 4'h1;
  localparam logic [3:0] RT_BUS_LAST = 4'h8;
  localparam logic [3:0] RT_READ = 4'ha;
  localparam logic [3:0] RT_WRITE = 4'hb;
  localparam logic [4:0] LEN_BUS = 5'h0b;
  localparam logic [4:0] LEN_READ = 5'h0a;
  localparam logic [4:0] LEN_WRITE = 5'h12;
  localparam logic [4:0] LEN_SHORT = 5'h06;
  typedef enum logic [6:0] {
    ST_DIS = 7'h01,
    ST_WAKE = 7'h02,
    ST_RST = 7'h04,
    ST_INIT = 7'h08,
    ST_RXI = 7'h10,
    ST_NORM = 7'h20,
    ST_LINK = 7'h40
  } pli_state_t;
  typedef struct packed {
    logic [1:0] ctl;
    logic [7:0] data;
  } pli_pins_t;
  typedef struct packed {
    logic [4:0] len;
    logic [REQ_MAX-1:0] bits;
  } pli_req_t;
endpackage : pli_pkg

// ===== tb/phy_link_interface_init_ctl_tb_top.sv
// Self-checking bench for the device end of the link interface.
// Assumes the link model drives the far side; checker bound below.
`timescale 1ns/100ps
module phy_link_interface_init_ctl_tb_top
  import pli_pkg::*;
;
  logic clk, rst, link_power_status, low_power_state, link_active_bit;
  logic rx_valid, st_valid, grant_req, irq_valid;
  logic [7:0] rx_data, st_data, irq_data;
  logic [7:0] tx_last = 8'h00;
  logic link_return_clock, link_request_line, iface_clk_out, bus_oe_n, link_wake_line;
  logic phy_serial_status_line, rx_ready, st_ready, grant_ack, tx_valid, req_valid;
  logic irq_ready;
  logic init_done;
  logic [7:0] tx_data;
  pli_pins_t bus_out, bus_in;
  pli_req_t req;
  int num_errors, checked, req_seen;
  // Short wake delay keeps the low-power restart quick
  pli_init_ctl #(.ACT_LP_CYCLES(20)) uut (.clk, .rst, .link_return_clock,
    .link_power_status, .low_power_state, .link_active_bit, .iface_clk_out, .bus_out,
    .bus_oe_n, .bus_in, .link_request_line, .link_wake_line, .phy_serial_status_line,
    .rx_valid, .rx_data, .rx_ready, .st_valid, .st_data, .st_ready, .grant_req,
    .grant_ack, .tx_valid, .tx_data, .irq_valid, .irq_data, .irq_ready, .req_valid,
    .req, .init_done);
  pli_link_model link (.clk, .bus_out, .bus_oe_n, .bus_in, .link_return_clock,
    .link_request_line);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (req_valid === 1'b1) req_seen++;
    if (tx_valid === 1'b1) tx_last <= tx_data;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_early_req();
    link.send_req(18'h0034a, 10);
    repeat (10) @(negedge clk);
    check(req_seen == 0 && iface_clk_out === 1'b0, "request taken while off");
    check(link_wake_line === 1'b1, "wake low while power off");
  endtask : t_early_req
  task automatic t_init(input logic lp, input int lo, input int hi, input int at);
    int n, r, seen;
    n = 0;
    @(posedge clk);
    low_power_state <= lp;
    link_power_status <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (iface_clk_out !== 1'b1);
    check(n >= lo && n <= hi, "clock restart delay");
    r = 1;
    seen = 0;
    while (init_done !== 1'b1 && r < 14) begin
      if (bus_out === {CTL_RECEIVE, DATA_ON}) seen = r;
      else check(bus_out === 10'h0 && bus_oe_n === 1'b0, "init lines not low");
      @(posedge iface_clk_out);
      @(negedge clk);
      r++;
    end
    check(seen > 0 && (at == 0 || seen == at), "receive indication");
    check(bus_out === 10'h0 && init_done === 1'b1, "init not complete");
  endtask : t_init
  task automatic t_wake();
    check(link_wake_line === 1'b0, "wake while link active");
    @(posedge clk);
    link_active_bit <= 1'b0;
    repeat (6) @(negedge clk);
    check(link_wake_line === 1'b1, "no wake on link off");
    @(posedge clk);
    link_active_bit <= 1'b1;
    repeat (6) @(negedge clk);
  endtask : t_wake
  task automatic put(input logic is_rx, input logic [7:0] d);
    @(posedge clk);
    rx_valid <= is_rx;
    st_valid <= !is_rx;
    rx_data <= d;
    st_data <= d;
    do @(negedge clk); while ((is_rx ? rx_ready : st_ready) !== 1'b1);
    @(posedge clk);
    rx_valid <= 1'b0;
    st_valid <= 1'b0;
    @(negedge clk);
    check(bus_out === {(is_rx ? CTL_RECEIVE : CTL_STATUS), d}, "byte code");
  endtask : put
  task automatic t_grant();
    check(bus_oe_n === 1'b0, "bus not owned");
    @(posedge clk);
    grant_req <= 1'b1;
    do @(negedge clk); while (grant_ack !== 1'b1);
    @(posedge clk);
    grant_req <= 1'b0;
    @(negedge clk);
    check(bus_out === {CTL_GRANT, DATA_ZERO}, "grant code");
    link.transmit(8'h3c);
    repeat (8) @(negedge clk);
    check(tx_last === 8'h3c, "transmit byte");
    check(bus_oe_n === 1'b0 && bus_out === 10'h0, "bus not returned");
  endtask : t_grant
  task automatic t_reqs();
    logic [17:0] pat [4] = '{18'h0034a, 18'h00448, 18'h00038, 18'h3674a};
    int len [4] = '{10, 11, 6, 18};
    int k;
    for (int i = 0; i < 4; i++) begin
      k = req_seen;
      link.send_req(pat[i], len[i]);
      for (int w = 0; w < 20 && req_seen == k; w++) @(negedge clk);
      check(req_seen == k + 1 && req.len === 5'(len[i]), "request length");
      check((req.bits & ((18'h1 << len[i]) - 18'h1)) === pat[i], "request bits");
    end
  endtask : t_reqs
  task automatic t_irq();
    int p;
    @(posedge clk);
    irq_valid <= 1'b1;
    irq_data <= 8'h5a;
    do @(negedge clk); while (irq_ready !== 1'b1);
    @(posedge clk);
    irq_valid <= 1'b0;
    p = 0;
    do @(negedge clk); while (phy_serial_status_line !== 1'b1);
    while (phy_serial_status_line === 1'b1) begin
      @(negedge clk);
      p++;
    end
    for (int i = 7; i >= 0; i--) begin
      check(phy_serial_status_line === irq_data[i], "status bit");
      repeat (p) @(negedge clk);
    end
    check(phy_serial_status_line === 1'b0, "status line not low");
  endtask : t_irq
  task automatic t_lps_off(input int n, input logic run);
    logic v;
    @(posedge clk);
    link_power_status <= 1'b0;
    repeat (n) @(negedge clk);
    v = iface_clk_out;
    @(negedge clk);
    check(bus_out === 10'h0 && bus_oe_n === 1'b0 && init_done === 1'b0, "no reset");
    check((v !== iface_clk_out) === run && (run || v === 1'b0), "clock state");
    check(link_wake_line === 1'b1, "wake low while off");
  endtask : t_lps_off
  ////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    link_power_status = 1'b0;
    low_power_state = 1'b0;
    link_active_bit = 1'b1;
    {rx_valid, st_valid, grant_req, irq_valid} = 4'h0;
    {rx_data, st_data, irq_data} = 24'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_early_req();
    t_init(1'b0, 1, 8, 8);
    t_wake();
    put(1'b1, 8'hc3);
    put(1'b1, 8'h3c);
    put(1'b0, 8'h81);
    t_grant();
    t_reqs();
    t_irq();
    t_lps_off(400, 1'b1);
    t_init(1'b0, 1, 8, 0);
    t_lps_off(600, 1'b0);
    t_init(1'b1, 20, 30, 8);
    put(1'b1, 8'h55);
    tally_and_finish();
  end
  initial begin
    #1_000_000;
    num_errors++;
    tally_and_finish();
  end
endmodule : phy_link_interface_init_ctl_tb_top
bind pli_init_ctl pli_init_ctl_assertions chk (.clk, .rst, .link_power_status,
  .link_active_bit, .iface_clk_out, .bus_out, .bus_oe_n, .link_wake_line, .rx_data,
  .rx_ready, .st_data, .st_ready, .grant_ack, .init_done);

// ===== tb/pli_init_ctl_assertions.sv
// Port-level checks on the device end of the link interface.
// Bound onto pli_init_ctl from the bench top; one clock domain.
`timescale 1ns/100ps
module pli_init_ctl_assertions
  import pli_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic link_power_status,
  input wire logic link_active_bit,
  input wire logic iface_clk_out,
  input wire pli_pins_t bus_out,
  input wire logic bus_oe_n,
  input wire logic link_wake_line,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic [7:0] st_data,
  input wire logic st_ready,
  input wire logic grant_ack,
  input wire logic init_done
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  ready_excl_a: assert property (rx_ready |-> !st_ready && !grant_ack)
    else $error("receive lost priority");
  ready_init_a: assert property (rx_ready || st_ready || grant_ack |-> init_done)
    else $error("operation taken before init");
  rx_code_a: assert property (rx_ready |=> bus_out.ctl == CTL_RECEIVE &&
    bus_out.data == $past(rx_data)) else $error("receive byte wrong");
  st_code_a: assert property (st_ready |=> bus_out.ctl == CTL_STATUS &&
    bus_out.data == $past(st_data)) else $error("status byte wrong");
  grant_flow_a: assert property (grant_ack |=> bus_out.ctl == CTL_GRANT ##[1:6] bus_oe_n)
    else $error("grant not followed by release");
  init_lines_a: assert property (!init_done |-> !bus_oe_n && (bus_out == 10'h0 ||
    bus_out == {CTL_RECEIVE, DATA_ON})) else $error("lines wrong before init");
  wake_flag_a: assert property (!link_power_status || !link_active_bit |->
    ##[0:5] link_wake_line) else $error("wake line not raised");
  clk_duty_a: assert property ($rose(iface_clk_out) |=> $fell(iface_clk_out))
    else $error("interface clock duty wrong");
  bus_edge_a: assert property (init_done && $changed(bus_out) |-> $rose(iface_clk_out))
    else $error("bus changed off clock rise");
endmodule : pli_init_ctl_assertions

// ===== tb/pli_link_model.sv
// Behavioural link-layer end: bus lines, returned clock, request line.
// Assumes the device drives the pins whenever its enable is low.
`timescale 1ns/100ps
module pli_link_model
  import pli_pkg::*;
(
  input wire logic clk,
  input wire pli_pins_t bus_out,
  input wire logic bus_oe_n,
  output pli_pins_t bus_in,
  output logic link_return_clock,
  output logic link_request_line
);
  logic drv;
  pli_pins_t val;
  initial begin
    drv = 1'b0;
    val = 10'h0;
    link_return_clock = 1'b0;
    link_request_line = 1'b0;
  end
  // No pull on these lines, so a released bus shows the inverse of the link's last driven value
  assign bus_in = (bus_oe_n === 1'b0) ? bus_out : (drv ? val : ~val);
  ////////////////////////////////////////////////////////////
  // Returned clock runs only while a request frame and its four idle bits are sent
  task automatic lbit(input logic b);
    link_request_line = b;
    #62.5 link_return_clock = 1'b1;
    #62.5 link_return_clock = 1'b0;
  endtask : lbit
  task automatic send_req(input logic [17:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      lbit(bits[i]);
    end
    repeat (4) lbit(1'b0); // Idle low flushes the far synchronizer
  endtask : send_req
  task automatic transmit(input logic [7:0] d);
    // Enable is looked at where it has settled, not at its launching edge
    while (bus_oe_n !== 1'b1) @(negedge clk);
    @(posedge clk);
    drv <= 1'b1;
    val <= {LCTL_TRANSMIT, d};
    repeat (2) @(posedge clk);
    val <= {LCTL_IDLE, DATA_ZERO};
    repeat (2) @(posedge clk);
    drv <= 1'b0;
  endtask : transmit
endmodule : pli_link_model
